// file: hw/stp_pkg.sv
package stp_pkg;

	// Register map of the plain register port
	localparam logic [1:0] GTC_OFFSET    = 2'h0;
	localparam logic [1:0] CSEL0_OFFSET  = 2'h1;
	localparam logic [1:0] CSEL1_OFFSET  = 2'h2;
	localparam logic [1:0] STATUS_OFFSET = 2'h3;

	// Field positions in general_timer_control
	localparam int GTC_SYNC_RST_BIT  = 0;
	localparam int GTC_ASYNC_RST_BIT = 1;
	localparam int GTC_HOLD_BIT      = 7;

	// Reset values
	localparam logic [7:0] GTC_RESET   = 8'h00;
	localparam logic [2:0] CSEL_RESET  = 3'h0;
	localparam logic [9:0] DIV_RESET   = 10'h000;

	// Divider width and tap masks, tap fires when low bits are all ones
	localparam int         DIV_WIDTH   = 10;
	localparam logic [9:0] TAP8_MASK    = 10'h007;
	localparam logic [9:0] TAP64_MASK   = 10'h03f;
	localparam logic [9:0] TAP256_MASK  = 10'h0ff;
	localparam logic [9:0] TAP1024_MASK = 10'h3ff;

	// Clock select encodings
	typedef enum logic [2:0] {
		CS_STOP    = 3'h0,
		CS_DIV1    = 3'h1,
		CS_DIV8    = 3'h2,
		CS_DIV64   = 3'h3,
		CS_DIV256  = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} stp_csel_type;

	// Divider tap pulses carried together
	typedef struct packed {
		logic tap1024;
		logic tap256;
		logic tap64;
		logic tap8;
	} stp_taps_type;

endpackage : stp_pkg

// file: hw/stp_ext_sync.sv
// Pin sampler and edge detector for one external count pin
module stp_ext_sync
(
	input  wire logic                 mclk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 pin_i,
	input  wire stp_pkg::stp_csel_type csel_i,
	output logic                      tick_o
);
	logic latch_q;
	logic sync_ff;
	logic edge_ff;
	logic rise;
	logic fall;

	// Latch open while clock is high, closes at falling edge
	always_latch
	begin
		if (mclk_i)
			latch_q = pin_i;
	end

	// Rising-edge stages after the latch
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync_ff <= 1'b0;
			edge_ff <= 1'b0;
		end
		else
		begin
			sync_ff <= latch_q;
			edge_ff <= sync_ff;
		end
	end

	assign rise = sync_ff & ~edge_ff;
	assign fall = ~sync_ff & edge_ff;

	// One pulse per selected edge; never routed through divider taps
	always_comb
	begin
		case (csel_i)
			stp_pkg::CS_EXT_RISE: tick_o = rise;
			stp_pkg::CS_EXT_FALL: tick_o = fall;
			default:              tick_o = 1'b0;
		endcase
	end
endmodule // stp_ext_sync

// file: hw/stp_prescaler.sv
// Operation
// - Each timer picks its clock independently from the shared divider.
// - Select value 1 gives the undivided system clock tick every cycle while the sync reset bit is clear.
// - Divider offers taps dividing by 8, 64, 256 and 1024.
// - Divider runs freely whatever the clock selects hold.
// - First count on tap N comes 2 to N+1 cycles after enable.
// - Divider reset restarts tap phases for both timers.
// - External pin sampled every system clock and fed to edge detector.
// - Synchroniser is a high-transparent latch then rising-edge flip-flops.
// - Select 7 counts rising pin edges, select 6 falling edges.
// - Pin edge reaches the counter 2.5 to 3.5 cycles later.
// - External edge ticks bypass the divider taps.
// - In hold mode both reset bits keep their written values.
// - Clearing hold mode clears both reset bits together.
// - Sync reset bit resets the divider and self-clears unless holding.
// - Select value 0 delivers no ticks.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
module stp_prescaler
(
	input  wire logic       mclk_i,
	input  wire logic       reset_n_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       ext_count_pin0_i,
	input  wire logic       ext_count_pin1_i,
	output logic            timer_tick0_o,
	output logic            timer_tick1_o,
	output logic            async_divider_reset_o,
	output logic            sync_divider_reset_o
);
	logic                   sync_hold_mode_ff;
	logic                   sync_rst_ff;
	logic                   async_rst_ff;
	stp_pkg::stp_csel_type  csel0_ff;
	stp_pkg::stp_csel_type  csel1_ff;
	logic [9:0]             div_ff;
	logic [9:0]             nxt_div;
	stp_pkg::stp_taps_type  taps;
	logic                   ext_tick0;
	logic                   ext_tick1;
	logic                   tick0_ff;
	logic                   tick1_ff;
	logic [7:0]             nxt_rdata;
	logic                   gtc_wr;

	assign gtc_wr = wr_i && (addr_i == stp_pkg::GTC_OFFSET);

	// Control bits; hold mode keeps reset bits asserted for aligned starts
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sync_hold_mode_ff <= stp_pkg::GTC_RESET[stp_pkg::GTC_HOLD_BIT];
			sync_rst_ff       <= stp_pkg::GTC_RESET[stp_pkg::GTC_SYNC_RST_BIT];
			async_rst_ff      <= stp_pkg::GTC_RESET[stp_pkg::GTC_ASYNC_RST_BIT];
		end
		else if (gtc_wr)
		begin
			sync_hold_mode_ff <= wdata_i[stp_pkg::GTC_HOLD_BIT];
			if (wdata_i[stp_pkg::GTC_HOLD_BIT])
			begin
				sync_rst_ff  <= wdata_i[stp_pkg::GTC_SYNC_RST_BIT];
				async_rst_ff <= wdata_i[stp_pkg::GTC_ASYNC_RST_BIT];
			end
			else
			begin
				// Written one still pulses for one cycle before clearing
				sync_rst_ff  <= wdata_i[stp_pkg::GTC_SYNC_RST_BIT];
				async_rst_ff <= wdata_i[stp_pkg::GTC_ASYNC_RST_BIT];
			end
		end
		else if (!sync_hold_mode_ff)
		begin
			// Self-clear outside hold; leaving hold releases both at once
			sync_rst_ff  <= 1'b0;
			async_rst_ff <= 1'b0;
		end
	end

	// Clock select fields, one per timer
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			csel0_ff <= stp_pkg::stp_csel_type'(stp_pkg::CSEL_RESET);
			csel1_ff <= stp_pkg::stp_csel_type'(stp_pkg::CSEL_RESET);
		end
		else if (wr_i)
		begin
			if (addr_i == stp_pkg::CSEL0_OFFSET)
				csel0_ff <= stp_pkg::stp_csel_type'(wdata_i[2:0]);
			if (addr_i == stp_pkg::CSEL1_OFFSET)
				csel1_ff <= stp_pkg::stp_csel_type'(wdata_i[2:0]);
		end
	end

	// Free-running divider, blind to clock selects
	always_comb
	begin
		if (sync_rst_ff)
			nxt_div = stp_pkg::DIV_RESET;
		else
			nxt_div = div_ff + 10'h001;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			div_ff <= stp_pkg::DIV_RESET;
		else
			div_ff <= nxt_div;
	end

	// Tap pulses, one cycle per period, suppressed while reset held
	assign taps.tap8    = !sync_rst_ff && ((div_ff & stp_pkg::TAP8_MASK) == stp_pkg::TAP8_MASK);
	assign taps.tap64   = !sync_rst_ff && ((div_ff & stp_pkg::TAP64_MASK) == stp_pkg::TAP64_MASK);
	assign taps.tap256  = !sync_rst_ff && ((div_ff & stp_pkg::TAP256_MASK) == stp_pkg::TAP256_MASK);
	assign taps.tap1024 = !sync_rst_ff
		&& ((div_ff & stp_pkg::TAP1024_MASK) == stp_pkg::TAP1024_MASK);

	// Pin synchronisers and edge detectors
	stp_ext_sync u_ext0
	(
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (ext_count_pin0_i),
		.csel_i    (csel0_ff),
		.tick_o    (ext_tick0)
	);

	stp_ext_sync u_ext1
	(
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (ext_count_pin1_i),
		.csel_i    (csel1_ff),
		.tick_o    (ext_tick1)
	);

	// Source selection per timer; ticks registered for clean data outputs
	function automatic logic pick(input stp_pkg::stp_csel_type cs,
		input stp_pkg::stp_taps_type tp, input logic ext, input logic hold);
		case (cs)
			stp_pkg::CS_STOP:     pick = 1'b0;
			stp_pkg::CS_DIV1:     pick = !hold;
			stp_pkg::CS_DIV8:     pick = tp.tap8;
			stp_pkg::CS_DIV64:    pick = tp.tap64;
			stp_pkg::CS_DIV256:   pick = tp.tap256;
			stp_pkg::CS_DIV1024:  pick = tp.tap1024;
			default:              pick = ext;
		endcase
	endfunction

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick0_ff <= 1'b0;
			tick1_ff <= 1'b0;
		end
		else
		begin
			tick0_ff <= pick(csel0_ff, taps, ext_tick0, sync_rst_ff);
			tick1_ff <= pick(csel1_ff, taps, ext_tick1, sync_rst_ff);
		end
	end

	assign timer_tick0_o         = tick0_ff;
	assign timer_tick1_o         = tick1_ff;
	assign sync_divider_reset_o  = sync_rst_ff;
	assign async_divider_reset_o = async_rst_ff;

	// Read mux; status shows divider low byte
	always_comb
	begin
		nxt_rdata = 8'h00;
		case (addr_i)
			stp_pkg::GTC_OFFSET:
				nxt_rdata = {sync_hold_mode_ff, 5'h00, async_rst_ff, sync_rst_ff};
			stp_pkg::CSEL0_OFFSET:  nxt_rdata = {5'h00, csel0_ff};
			stp_pkg::CSEL1_OFFSET:  nxt_rdata = {5'h00, csel1_ff};
			stp_pkg::STATUS_OFFSET: nxt_rdata = div_ff[7:0];
			default:                nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= nxt_rdata;
		else
			rdata_o <= 8'h00;
	end
endmodule // stp_prescaler

// file: dv/stp_prescaler_chk.sv
module stp_prescaler_chk
(
	input wire logic       mclk_i,
	input wire logic       reset_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       ext_count_pin0_i,
	input wire logic       ext_count_pin1_i,
	input wire logic       timer_tick0_o,
	input wire logic       timer_tick1_o,
	input wire logic       async_divider_reset_o,
	input wire logic       sync_divider_reset_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cs0_ff;
	logic [2:0] cs1_ff;
	logic       gw;
	// Control writes, decoded once
	assign gw = wr_i && addr_i == 2'h0;
	// Shadow of the selects, since the checker sees only ports
	always_ff @(posedge mclk_i or negedge reset_n_i)
		if (!reset_n_i)
			{cs0_ff, cs1_ff} <= 6'h00;
		else if (wr_i && addr_i == 2'h1)
			cs0_ff <= wdata_i[2:0];
		else if (wr_i && addr_i == 2'h2)
			cs1_ff <= wdata_i[2:0];
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	AST_SYNC_PULSE: assert property (gw && wdata_i == 8'h01 |=>
		sync_divider_reset_o ##1 !sync_divider_reset_o) else $error("sync reset not one pulse");
	AST_ASYNC_PULSE: assert property (gw && wdata_i == 8'h02 |=>
		async_divider_reset_o ##1 !async_divider_reset_o) else $error("async reset not one pulse");
	AST_HOLD_KEEP: assert property (gw && wdata_i == 8'h83 |=>
		(sync_divider_reset_o && async_divider_reset_o) [*4]) else $error("hold lost");
	AST_HOLD_RELEASE: assert property (gw && wdata_i == 8'h00 |=>
		!sync_divider_reset_o && !async_divider_reset_o) else $error("release failed");
	AST_STOP: assert property (cs1_ff == 3'h0 && $past(cs1_ff) == 3'h0 |->
		!timer_tick1_o) else $error("tick while stopped");
	AST_DIV1: assert property ((cs0_ff == 3'h1 && !sync_divider_reset_o) [*2] |->
		timer_tick0_o) else $error("missing undivided tick");
	AST_DIV8: assert property (cs1_ff == 3'h2 && timer_tick1_o |=>
		!timer_tick1_o [*7]) else $error("divide by 8 too fast");
	AST_EXT_RISE: assert property (cs0_ff == 3'h7 && $rose(ext_count_pin0_i) |->
		##[2:4] timer_tick0_o) else $error("rising edge tick late");
	AST_EXT_FALL: assert property (cs1_ff == 3'h6 && $fell(ext_count_pin1_i) |->
		##[2:4] timer_tick1_o) else $error("falling edge tick late");
	// Main scenarios reached
	cover property (timer_tick1_o && cs1_ff == 3'h6);
	cover property (sync_divider_reset_o && async_divider_reset_o);
	cover property (timer_tick0_o && cs0_ff == 3'h5);
endmodule // stp_prescaler_chk

bind stp_prescaler stp_prescaler_chk stp_prescaler_chk_inst (.mclk_i(mclk_i),
	.reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .ext_count_pin0_i(ext_count_pin0_i), .ext_count_pin1_i(ext_count_pin1_i),
	.timer_tick0_o(timer_tick0_o), .timer_tick1_o(timer_tick1_o),
	.async_divider_reset_o(async_divider_reset_o), .sync_divider_reset_o(sync_divider_reset_o));

// file: dv/stp_timer_model.sv
module stp_timer_model
(
	input  wire logic        mclk_i,
	input  wire logic        reset_n_i,
	input  wire logic        tick_i,
	output logic      [15:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Counter moves only on a tick, like the real timer unit
	always_ff @(posedge mclk_i or negedge reset_n_i)
		if (!reset_n_i)
			cnt_o <= 16'h0000;
		else if (tick_i)
			cnt_o <= cnt_o + 16'h0001;
endmodule // stp_timer_model

// file: dv/stp_prescaler_tb.sv
module stp_prescaler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic        pin0 = 1'b0, pin1 = 1'b0, tk0, tk1, ar, sr;
	logic [1:0]  addr_i = 2'h0;
	logic [7:0]  wdata_i = 8'h00, rdata_o, d, d2;
	logic [15:0] c0, c1, b0, b1;
	int          errors = 0, n_compared = 0;
	// Rows: select 0, select 1, ticks of each over 1024 cycles
	logic [37:0] rows [4] = '{{3'h1, 3'h2, 16'h0400, 16'h0080}, {3'h3, 3'h4, 16'h0010, 16'h0004},
		{3'h5, 3'h0, 16'h0001, 16'h0000}, {3'h6, 3'h7, 16'h0000, 16'h0000}};
	stp_prescaler stp_prescaler_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_count_pin0_i(pin0),
		.ext_count_pin1_i(pin1), .timer_tick0_o(tk0), .timer_tick1_o(tk1),
		.async_divider_reset_o(ar), .sync_divider_reset_o(sr));
	stp_timer_model stp_timer_model_inst0 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tick_i(tk0),
		.cnt_o(c0));
	stp_timer_model stp_timer_model_inst1 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tick_i(tk1),
		.cnt_o(c1));
	// Clock of 50 ns
	always #25 mclk_i = ~mclk_i;
	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Register write, strobe released one edge later
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// Register read, data taken mid-cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		@(negedge mclk_i);
		v = rdata_o;
	endtask
	// Snapshot both timer counts away from the edge
	task automatic snap();
		@(negedge mclk_i);
		b0 = c0;
		b1 = c1;
	endtask
	task automatic complete_run();
		$display("Compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog, the run needs about 4300 cycles
	initial
	begin
		#1000000;
		errors++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		repeat (5) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		rd(2'h0, d);
		check("control", d, 8'h00);
		foreach (rows[i])
		begin
			wr(2'h1, {5'h00, rows[i][37:35]});
			wr(2'h2, {5'h00, rows[i][34:32]});
			repeat (4) @(posedge mclk_i);
			snap();
			repeat (1024) @(posedge mclk_i);
			@(negedge mclk_i);
			check("ticks0", c0 - b0, rows[i][31:16]);
			check("ticks1", c1 - b1, rows[i][15:0]);
		end
		rd(2'h3, d);
		wr(2'h1, 8'h02);
		rd(2'h3, d2);
		check("divider", 8'(d2 - d), 8'h04);
		wr(2'h0, 8'h01);
		rd(2'h3, d);
		check("restart", d, 8'h00);
		wr(2'h0, 8'h02);
		wr(2'h1, 8'h01);
		wr(2'h2, 8'h01);
		wr(2'h0, 8'h83);
		repeat (4) @(posedge mclk_i);
		snap();
		rd(2'h0, d);
		check("held", {sr, ar, d}, 10'h383);
		check("halted", c0 - b0, 16'h0000);
		snap();
		wr(2'h0, 8'h00);
		repeat (20) @(posedge mclk_i);
		@(negedge mclk_i);
		// Release seen at the write edge, first tick one edge later, counted from the next
		check("together", c0 - b0, 16'h0013);
		check("together1", c1 - b1, 16'h0013);
		check("released", {sr, ar}, 2'h0);
		wr(2'h1, 8'h07);
		wr(2'h2, 8'h06);
		repeat (4) @(posedge mclk_i);
		snap();
		// Phases of three cycles keep the pin clock slow enough
		repeat (10)
		begin
			repeat (3) @(posedge mclk_i);
			pin0 <= 1'b1;
			pin1 <= 1'b1;
			repeat (3) @(posedge mclk_i);
			pin0 <= 1'b0;
			pin1 <= 1'b0;
		end
		repeat (8) @(posedge mclk_i);
		@(negedge mclk_i);
		check("rising", c0 - b0, 16'h000a);
		check("falling", c1 - b1, 16'h000a);
		complete_run();
	end
endmodule // stp_prescaler_tb
